// *** src/mil_pkg.sv ***
// Package for the monitor interrupt mask, offset and supply limit block.
// Assumes a byte-wide register port driven by the serial interface logic.
package mil_pkg;
	// ********************************************************************
	// Register offsets
	// ********************************************************************
	localparam logic [7:0] OFF_EVENT_GATE_LOW  = 8'h1D;
	localparam logic [7:0] OFF_EVENT_GATE_HIGH = 8'h1E;
	localparam logic [7:0] OFF_INNER_TRIM      = 8'h1F;
	localparam logic [7:0] OFF_REMOTE_TRIM     = 8'h20;
	localparam logic [7:0] OFF_SUPPLY_UPPER    = 8'h23;
	localparam logic [7:0] OFF_SUPPLY_LOWER    = 8'h24;

	// ********************************************************************
	// Reset values
	// ********************************************************************
	localparam logic [7:0] RST_GATE         = 8'h00;
	localparam logic [7:0] RST_TRIM         = 8'h00;
	localparam logic [7:0] RST_SUPPLY_UPPER = 8'hC7;
	localparam logic [7:0] RST_SUPPLY_LOWER = 8'h62;

	// ********************************************************************
	// Field positions
	// ********************************************************************
	localparam int BIT_INNER_UPPER   = 0;
	localparam int BIT_INNER_LOWER   = 1;
	localparam int BIT_REMOTE_UPPER  = 2;
	localparam int BIT_REMOTE_LOWER  = 3;
	localparam int BIT_REMOTE_FAULT  = 4;
	localparam int BIT_ANALOG_2      = 5;
	localparam int BIT_ANALOG_5      = 0;
	localparam int BIT_SUPPLY        = 4;
	localparam int ANALOG_HIGH_COUNT = 4;
endpackage : mil_pkg

// *** src/mil_top.sv ***
// Mask, temperature offset and supply limit registers of the monitor.
// Assumes a byte register port from the serial logic and event levels
// from the limit comparators; supply code arrives from the converter.
//
// Contract
// - Each mask bit set to one blocks its event from the interrupt.
// - Low mask bit 0 gates inner upper, bit 1 inner lower.
// - Low mask bit 2 gates remote upper or analog 1, bit 3 remote lower.
// - Low mask bit 4 gates remote sensor fault.
// - Low mask bits 5 to 7 gate analog inputs two to four.
// - High mask bits 0 to 3 gate analog inputs five to eight.
// - High mask bit 4 gates both supply events together.
// - Inner offset is added before storing and comparing.
// - Remote offset is added before storing and comparing.
// - Offsets are 8-bit two's complement, one degree per step.
// - Supply upper event when code strictly above upper threshold.
// - Supply lower event when code at or below lower threshold.
// - Supply upper threshold resets to C7.
// - Supply lower threshold resets to 62.
// - Masks and offsets reset to zero.
// - Software reset returns every mapped register to its default; read data and offset sums see rst only.
`timescale 1ns/1ns
module mil_top (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        soft_rst,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic [7:0]       reg_rdata,
	input  wire logic        inner_valid,
	input  wire logic [9:0]  inner_raw,
	input  wire logic        remote_valid,
	input  wire logic [9:0]  remote_raw,
	output logic             inner_sum_valid,
	output logic [9:0]       inner_sum,
	output logic             remote_sum_valid,
	output logic [9:0]       remote_sum,
	input  wire logic        supply_valid,
	input  wire logic [7:0]  supply_code,
	input  wire logic        temp_upper_event,
	input  wire logic        temp_lower_event,
	input  wire logic        remote_upper_event,
	input  wire logic        remote_lower_event,
	input  wire logic        remote_fault_event,
	input  wire logic [7:1]  analog_in_event,
	output logic             volt_upper_event,
	output logic             volt_lower_event,
	output logic             irq
);
	// ********************************************************************
	// Registers
	// ********************************************************************
	logic [7:0] event_gate_low_reg;
	logic [7:0] event_gate_high_reg;
	logic [7:0] inner_temp_trim_reg;
	logic [7:0] remote_temp_trim_reg;
	logic [7:0] supply_upper_threshold_reg;
	logic [7:0] supply_lower_threshold_reg;
	logic       any_rst;
	logic [7:0] low_events;
	logic [4:0] high_events;

	// Software reset acts like power-up for the registers, supply events and irq; read data and adders see rst only
	assign any_rst = rst | soft_rst;

	// Mask registers
	always_ff @(posedge clk) begin
		if (any_rst) begin
			event_gate_low_reg  <= mil_pkg::RST_GATE;
			event_gate_high_reg <= mil_pkg::RST_GATE;
		end else if (reg_wr) begin
			if (reg_addr == mil_pkg::OFF_EVENT_GATE_LOW) begin
				event_gate_low_reg <= reg_wdata;
			end
			if (reg_addr == mil_pkg::OFF_EVENT_GATE_HIGH) begin
				// Upper bits kept as written; host must write zero there
				event_gate_high_reg <= reg_wdata;
			end
		end
	end

	// Offset registers
	always_ff @(posedge clk) begin
		if (any_rst) begin
			inner_temp_trim_reg  <= mil_pkg::RST_TRIM;
			remote_temp_trim_reg <= mil_pkg::RST_TRIM;
		end else if (reg_wr) begin
			if (reg_addr == mil_pkg::OFF_INNER_TRIM) begin
				inner_temp_trim_reg <= reg_wdata;
			end
			if (reg_addr == mil_pkg::OFF_REMOTE_TRIM) begin
				remote_temp_trim_reg <= reg_wdata;
			end
		end
	end

	// Supply thresholds
	always_ff @(posedge clk) begin
		if (any_rst) begin
			supply_upper_threshold_reg <= mil_pkg::RST_SUPPLY_UPPER;
			supply_lower_threshold_reg <= mil_pkg::RST_SUPPLY_LOWER;
		end else if (reg_wr) begin
			if (reg_addr == mil_pkg::OFF_SUPPLY_UPPER) begin
				supply_upper_threshold_reg <= reg_wdata;
			end
			if (reg_addr == mil_pkg::OFF_SUPPLY_LOWER) begin
				supply_lower_threshold_reg <= reg_wdata;
			end
		end
	end

	// Read data registered; unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			unique case (reg_addr)
				mil_pkg::OFF_EVENT_GATE_LOW:  reg_rdata <= event_gate_low_reg;
				mil_pkg::OFF_EVENT_GATE_HIGH: reg_rdata <= event_gate_high_reg;
				mil_pkg::OFF_INNER_TRIM:      reg_rdata <= inner_temp_trim_reg;
				mil_pkg::OFF_REMOTE_TRIM:     reg_rdata <= remote_temp_trim_reg;
				mil_pkg::OFF_SUPPLY_UPPER:    reg_rdata <= supply_upper_threshold_reg;
				mil_pkg::OFF_SUPPLY_LOWER:    reg_rdata <= supply_lower_threshold_reg;
				default:                      reg_rdata <= 8'h00;
			endcase
		end
	end

	// ********************************************************************
	// Offset adders
	// ********************************************************************
	mil_trim_add u_inner (
		.clk       (clk),
		.rst       (rst),
		.raw_valid (inner_valid),
		.raw_temp  (inner_raw),
		.trim      (inner_temp_trim_reg),
		.sum_valid (inner_sum_valid),
		.sum_temp  (inner_sum)
	);

	mil_trim_add u_remote (
		.clk       (clk),
		.rst       (rst),
		.raw_valid (remote_valid),
		.raw_temp  (remote_raw),
		.trim      (remote_temp_trim_reg),
		.sum_valid (remote_sum_valid),
		.sum_temp  (remote_sum)
	);

	// ********************************************************************
	// Supply comparison
	// ********************************************************************
	// Events held until the next supply result; directions are fixed
	always_ff @(posedge clk) begin
		if (any_rst) begin
			volt_upper_event <= 1'b0;
			volt_lower_event <= 1'b0;
		end else if (supply_valid) begin
			volt_upper_event <= supply_code > supply_upper_threshold_reg;
			volt_lower_event <= supply_code <= supply_lower_threshold_reg;
		end
	end

	// ********************************************************************
	// Interrupt gating
	// ********************************************************************
	// Low gate order: inner upper, inner lower, remote upper, remote lower,
	// remote fault, then analog inputs two to four in the top three bits
	assign low_events = {analog_in_event[4:2],
	                     remote_fault_event,
	                     remote_lower_event,
	                     remote_upper_event | analog_in_event[1],
	                     temp_lower_event,
	                     temp_upper_event};

	// Analog input eight has no event pin on this block; its gate bit is
	// stored and read back but always guards an idle event
	logic analog_8_event;
	assign analog_8_event = 1'b0;

	// High gate order follows the register: analog five to eight, supply
	assign high_events = {volt_upper_event | volt_lower_event,
	                      analog_8_event,
	                      analog_in_event[7:5]};

	// True when any event finds its gate bit clear
	function automatic logic gate_any(
		input logic [7:0] events,
		input logic [7:0] gate
	);
		return |(events & ~gate);
	endfunction : gate_any

	// Mask bit one blocks; output is the OR of what gets through. Registered
	// so the pin cannot glitch while an event and its gate change together,
	// at the cost of one cycle of latency after either changes.
	// High gate bits 5 to 7 meet zeros, so a stray one there blocks nothing.
	always_ff @(posedge clk) begin
		if (any_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= gate_any(low_events, event_gate_low_reg)
			     | gate_any({3'b000, high_events}, event_gate_high_reg);
		end
	end

	// ********************************************************************
	// Checks
	// ********************************************************************
	// Supply and interrupt checks are disabled by either reset; the adders see only the
	// power-up reset, so their checks ride through a software reset.
	// Low gate fully set and high gate bits 0 to 4 set on two edges in a row
	sequence s_all_masked;
		(event_gate_low_reg == 8'hFF && event_gate_high_reg[4:0] == 5'h1F)
		##1 (event_gate_low_reg == 8'hFF && event_gate_high_reg[4:0] == 5'h1F);
	endsequence : s_all_masked

	// Only the supply events could be open, and their gate bit is set
	sequence s_supply_closed;
		(low_events & ~event_gate_low_reg) == 8'h00
		&& (analog_in_event[7:5] & ~event_gate_high_reg[mil_pkg::BIT_ANALOG_5 +: 3]) == 3'b000
		&& event_gate_high_reg[mil_pkg::BIT_SUPPLY];
	endsequence : s_supply_closed

	// One software reset pulse outside a power-up reset
	sequence s_soft_pulse;
		soft_rst && !rst;
	endsequence : s_soft_pulse

	// Supply compare directions are fixed: strictly above, at or below.
	// A code equal to the upper threshold is still inside the window.
	a_upper_strict: assert property (@(posedge clk) disable iff (any_rst)
		supply_valid |=> volt_upper_event == ($past(supply_code) >
		$past(supply_upper_threshold_reg))) else $error("supply upper compare wrong");
	a_lower_equal: assert property (@(posedge clk) disable iff (any_rst)
		supply_valid |=> volt_lower_event == ($past(supply_code) <=
		$past(supply_lower_threshold_reg))) else $error("supply lower compare wrong");

	// Supply events stand until the next supply result
	a_supply_stands: assert property (@(posedge clk) disable iff (any_rst)
		!supply_valid |=> $stable(volt_upper_event) && $stable(volt_lower_event))
		else $error("supply event moved without a result");

	// Defaults after either reset; the sampled value is the one just loaded
	a_reset_upper: assert property (@(posedge clk)
		$past(any_rst) |-> supply_upper_threshold_reg == mil_pkg::RST_SUPPLY_UPPER)
		else $error("upper threshold default wrong");
	a_reset_lower: assert property (@(posedge clk)
		$past(any_rst) |-> supply_lower_threshold_reg == mil_pkg::RST_SUPPLY_LOWER)
		else $error("lower threshold default wrong");
	a_reset_zero: assert property (@(posedge clk)
		$past(any_rst) |-> (event_gate_low_reg | event_gate_high_reg |
		inner_temp_trim_reg | remote_temp_trim_reg) == 8'h00)
		else $error("mask or offset default wrong");

	// A fully set gate keeps the interrupt low whatever is pending
	a_mask_blocks: assert property (@(posedge clk) disable iff (any_rst)
		s_all_masked |-> !irq)
		else $error("masked event reached interrupt");

	// The interrupt never rises without an open event behind it
	a_irq_has_cause: assert property (@(posedge clk) disable iff (any_rst)
		irq |-> ($past(low_events & ~event_gate_low_reg) != 8'h00
		|| $past(high_events & ~event_gate_high_reg[4:0]) != 5'h00))
		else $error("interrupt without an open event");

	// Each open event reaches the interrupt one edge later
	a_inner_upper_pass: assert property (@(posedge clk) disable iff (any_rst)
		(temp_upper_event && !event_gate_low_reg[mil_pkg::BIT_INNER_UPPER]) |=> irq)
		else $error("open inner upper event missed");
	a_inner_lower_pass: assert property (@(posedge clk) disable iff (any_rst)
		(temp_lower_event && !event_gate_low_reg[mil_pkg::BIT_INNER_LOWER]) |=> irq)
		else $error("open inner lower event missed");
	a_remote_upper_pass: assert property (@(posedge clk) disable iff (any_rst)
		((remote_upper_event || analog_in_event[1])
		&& !event_gate_low_reg[mil_pkg::BIT_REMOTE_UPPER]) |=> irq)
		else $error("open remote upper event missed");
	a_remote_lower_pass: assert property (@(posedge clk) disable iff (any_rst)
		(remote_lower_event && !event_gate_low_reg[mil_pkg::BIT_REMOTE_LOWER]) |=> irq)
		else $error("open remote lower event missed");
	a_fault_passes: assert property (@(posedge clk) disable iff (any_rst)
		(remote_fault_event && !event_gate_low_reg[mil_pkg::BIT_REMOTE_FAULT]) |=> irq)
		else $error("unmasked fault missed");
	a_analog_low_pass: assert property (@(posedge clk) disable iff (any_rst)
		(analog_in_event[4:2] & ~event_gate_low_reg[mil_pkg::BIT_ANALOG_2 +: 3]) != 3'b000
		|=> irq)
		else $error("open analog event two to four missed");
	a_analog_high_pass: assert property (@(posedge clk) disable iff (any_rst)
		(analog_in_event[7:5] & ~event_gate_high_reg[mil_pkg::BIT_ANALOG_5 +: 3]) != 3'b000
		|=> irq)
		else $error("open analog event five to seven missed");
	a_supply_pass: assert property (@(posedge clk) disable iff (any_rst)
		((volt_upper_event || volt_lower_event) && !event_gate_high_reg[mil_pkg::BIT_SUPPLY])
		|=> irq)
		else $error("open supply event missed");

	// One gate bit closes both supply events together
	a_supply_blocked: assert property (@(posedge clk) disable iff (any_rst)
		s_supply_closed |=> !irq)
		else $error("gated supply event reached interrupt");

	// Offset sums land one edge after their sample, wrapping in ten bits
	a_inner_sum: assert property (@(posedge clk) disable iff (rst)
		inner_valid |=> inner_sum == 10'($past(inner_raw) + {$past(inner_temp_trim_reg), 2'b00}))
		else $error("inner offset sum wrong");
	a_remote_sum: assert property (@(posedge clk) disable iff (rst)
		remote_valid |=> remote_sum ==
		10'($past(remote_raw) + {$past(remote_temp_trim_reg), 2'b00}))
		else $error("remote offset sum wrong");
	a_sum_pulse: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> inner_sum_valid == $past(inner_valid) && remote_sum_valid == $past(remote_valid))
		else $error("sum valid pulse misplaced");

	// Software reset clears the supply events and the interrupt at once
	a_soft_clear: assert property (@(posedge clk) disable iff (rst)
		s_soft_pulse |=> !irq && !volt_upper_event && !volt_lower_event)
		else $error("software reset incomplete");
	// It also reloads every register default in the same edge
	a_soft_defaults: assert property (@(posedge clk) disable iff (rst)
		s_soft_pulse |=> event_gate_low_reg == mil_pkg::RST_GATE
		&& event_gate_high_reg == mil_pkg::RST_GATE
		&& inner_temp_trim_reg == mil_pkg::RST_TRIM
		&& remote_temp_trim_reg == mil_pkg::RST_TRIM
		&& supply_upper_threshold_reg == mil_pkg::RST_SUPPLY_UPPER
		&& supply_lower_threshold_reg == mil_pkg::RST_SUPPLY_LOWER)
		else $error("software reset left a register changed");

	// Read data follows the address one edge later
	a_rdata_gate_low: assert property (@(posedge clk) disable iff (rst)
		reg_addr == mil_pkg::OFF_EVENT_GATE_LOW |=> reg_rdata == $past(event_gate_low_reg))
		else $error("low gate readback wrong");
	a_rdata_gate_high: assert property (@(posedge clk) disable iff (rst)
		reg_addr == mil_pkg::OFF_EVENT_GATE_HIGH |=> reg_rdata == $past(event_gate_high_reg))
		else $error("high gate readback wrong");
	a_rdata_upper: assert property (@(posedge clk) disable iff (rst)
		reg_addr == mil_pkg::OFF_SUPPLY_UPPER |=> reg_rdata == $past(supply_upper_threshold_reg))
		else $error("upper threshold readback wrong");
	a_rdata_lower: assert property (@(posedge clk) disable iff (rst)
		reg_addr == mil_pkg::OFF_SUPPLY_LOWER |=> reg_rdata == $past(supply_lower_threshold_reg))
		else $error("lower threshold readback wrong");
endmodule : mil_top

// *** src/mil_trim_add.sv ***
// Signed offset adder for one temperature channel.
// Assumes a 10-bit two's complement result in quarter degrees.
`timescale 1ns/1ns
module mil_trim_add (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        raw_valid,
	input  wire logic [9:0]  raw_temp,
	input  wire logic [7:0]  trim,
	output logic             sum_valid,
	output logic [9:0]       sum_temp
);
	logic [9:0] trim_ext;

	// Whole degrees scaled to quarter degrees; wraps like the raw code
	assign trim_ext = {trim, 2'b00};

	// Sum is registered so stored and compared values are one and the same
	always_ff @(posedge clk) begin
		if (rst) begin
			sum_valid <= 1'b0;
			sum_temp  <= 10'h000;
		end else begin
			sum_valid <= raw_valid;
			if (raw_valid) begin
				sum_temp <= raw_temp + trim_ext;
			end
		end
	end
endmodule : mil_trim_add

// *** test/mil_host.sv ***
// Host model: issues byte writes and reads on the register port.
// Assumes the bench calls its tasks; signals move on falling edges.
`timescale 1ns/1ns
module mil_host (
	input  wire logic       clk,
	input  wire logic [7:0] reg_rdata,
	output logic            reg_wr,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata
);
	// Idle port values before the first access
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Strobe spans one rising edge; data spoiled after so stale bytes never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = (a == mil_pkg::OFF_EVENT_GATE_HIGH) ? (d & 8'h1F) : d;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~reg_wdata;
	endtask : wr
	// Read data is registered, so it is taken one edge after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd
endmodule : mil_host

// *** test/mil_top_tb.sv ***
// Self-checking bench for the mask, offset and supply limit block.
// Assumes the host model drives the register port.
`timescale 1ns/1ns
module mil_top_tb;
	typedef struct packed {logic [11:0] ev; logic [7:0] ml; logic [7:0] mh; logic q;} mil_row_type;
	logic       clk = 1'b0, rst = 1'b1, soft_rst = 1'b0, irq, up, lo, iv, rv;
	logic       inner_valid = 1'b0, remote_valid = 1'b0, supply_valid = 1'b0, reg_wr;
	logic [9:0] inner_raw = 10'h000, remote_raw = 10'h000, inner_sum, remote_sum;
	logic [7:0] supply_code = 8'h00, reg_addr, reg_wdata, reg_rdata;
	logic [11:0] ev = 12'h000;
	int         n_errors = 0, compares = 0;
	logic [7:0] offs [7] = '{8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h23, 8'h24, 8'h30};
	logic [7:0] defs [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hC7, 8'h62, 8'h00};
	// Event bits: 0 inner up, 1 inner low, 2 remote up, 3 remote low, 4 fault, 5..11 analog 1..7
	mil_row_type rows [19] = '{'{12'h001, 8'h00, 8'h00, 1'b1}, '{12'h001, 8'h01, 8'h00, 1'b0},
		'{12'h002, 8'h01, 8'h00, 1'b1}, '{12'h002, 8'h02, 8'h00, 1'b0},
		'{12'h004, 8'h04, 8'h00, 1'b0}, '{12'h020, 8'h04, 8'h00, 1'b0},
		'{12'h020, 8'h00, 8'h00, 1'b1}, '{12'h008, 8'h08, 8'h00, 1'b0},
		'{12'h010, 8'h10, 8'h00, 1'b0}, '{12'h010, 8'hEF, 8'h1F, 1'b1},
		'{12'h040, 8'h20, 8'h00, 1'b0}, '{12'h080, 8'h40, 8'h00, 1'b0},
		'{12'h100, 8'h80, 8'h00, 1'b0}, '{12'h100, 8'h7F, 8'h00, 1'b1},
		'{12'h200, 8'h00, 8'h01, 1'b0}, '{12'h800, 8'h00, 8'h04, 1'b0},
		'{12'h800, 8'h00, 8'h08, 1'b1}, '{12'h400, 8'h00, 8'h02, 1'b0},
		'{12'hFFF, 8'hFF, 8'hFF, 1'b0}};
	always #20 clk = ~clk;
	mil_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata));
	mil_top uut (.clk(clk), .rst(rst), .soft_rst(soft_rst), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.inner_valid(inner_valid), .inner_raw(inner_raw), .remote_valid(remote_valid),
		.remote_raw(remote_raw), .inner_sum_valid(iv), .inner_sum(inner_sum),
		.remote_sum_valid(rv), .remote_sum(remote_sum), .supply_valid(supply_valid),
		.supply_code(supply_code), .temp_upper_event(ev[0]), .temp_lower_event(ev[1]),
		.remote_upper_event(ev[2]), .remote_lower_event(ev[3]), .remote_fault_event(ev[4]),
		.analog_in_event(ev[11:5]), .volt_upper_event(up), .volt_lower_event(lo), .irq(irq));
	// ******************************************************************
	// Shared tasks
	// ******************************************************************
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chk_defaults();
		logic [7:0] d;
		for (int i = 0; i < 7; i++) begin
			host.rd(offs[i], d);
			chk("register", {2'b00, defs[i]}, {2'b00, d});
		end
	endtask : chk_defaults
	// One supply sample; code spoiled afterwards so a stale code is never reused
	task automatic sup(input logic [7:0] c);
		@(negedge clk);
		supply_valid = 1'b1;
		supply_code = c;
		@(negedge clk);
		supply_valid = 1'b0;
		supply_code = ~c;
	endtask : sup
	task automatic tmp(input logic [9:0] ri, input logic [9:0] rr);
		@(negedge clk);
		{inner_valid, remote_valid, inner_raw, remote_raw} = {2'b11, ri, rr};
		@(negedge clk);
		{inner_valid, remote_valid} = 2'b00;
		chk("inner valid", 10'h001, {9'h000, iv});
		chk("remote valid", 10'h001, {9'h000, rv});
	endtask : tmp
	task automatic print_verdict();
		$display("counts: %0d compares, %0d mismatches", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : print_verdict
	// Guard against a hang anywhere in the sequence
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		print_verdict();
	end
	// ******************************************************************
	// Main sequence
	// ******************************************************************
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		chk_defaults();
		$display("test reset defaults done");
		foreach (rows[i]) begin
			host.wr(mil_pkg::OFF_EVENT_GATE_LOW, rows[i].ml);
			host.wr(mil_pkg::OFF_EVENT_GATE_HIGH, rows[i].mh);
			ev = rows[i].ev;
			repeat (2) @(negedge clk);
			chk("irq", {9'h000, rows[i].q}, {9'h000, irq});
		end
		$display("test mask table done");
		ev = 12'h000;
		host.wr(mil_pkg::OFF_EVENT_GATE_LOW, 8'h00);
		host.wr(mil_pkg::OFF_EVENT_GATE_HIGH, 8'h00);
		host.wr(mil_pkg::OFF_SUPPLY_UPPER, 8'h50);
		sup(8'h51);
		chk("upper", 10'h001, {9'h000, up});
		sup(8'h50);
		chk("upper", 10'h000, {9'h000, up});
		sup(8'h62);
		chk("lower", 10'h001, {9'h000, lo});
		@(negedge clk);
		chk("irq", 10'h001, {9'h000, irq});
		host.wr(mil_pkg::OFF_EVENT_GATE_HIGH, 8'h10);
		@(negedge clk);
		chk("irq", 10'h000, {9'h000, irq});
		sup(8'h63);
		chk("lower", 10'h000, {9'h000, lo});
		$display("test supply limits done");
		host.wr(mil_pkg::OFF_INNER_TRIM, 8'hFF);
		host.wr(mil_pkg::OFF_REMOTE_TRIM, 8'h80);
		tmp(10'h010, 10'h000);
		chk("inner sum", 10'h00C, inner_sum);
		chk("remote sum", 10'h200, remote_sum);
		host.wr(mil_pkg::OFF_INNER_TRIM, 8'h7F);
		host.wr(mil_pkg::OFF_REMOTE_TRIM, 8'h01);
		tmp(10'h3FF, 10'h1FF);
		chk("inner sum", 10'h1FB, inner_sum);
		chk("remote sum", 10'h203, remote_sum);
		$display("test offsets done");
		host.wr(mil_pkg::OFF_EVENT_GATE_LOW, 8'h5A);
		host.wr(8'h30, 8'hFF);
		@(negedge clk);
		soft_rst = 1'b1;
		@(negedge clk);
		soft_rst = 1'b0;
		chk_defaults();
		chk("upper", 10'h000, {9'h000, up});
		$display("test soft reset done");
		print_verdict();
	end
endmodule : mil_top_tb
